// *** ccp_pkg.sv ***
// Shared constants and types for the capture unit pair and timer routing.
// Assumes one 20 MHz core clock and a synchronous active-low reset.
package ccp_pkg;

    // Mode codes on the low four control bits
    localparam logic [3:0] MODE_OFF = 4'h0;
    localparam logic [3:0] MODE_CMP_TOGGLE = 4'h2;
    localparam logic [3:0] MODE_CAP_FALL = 4'h4;
    localparam logic [3:0] MODE_CAP_RISE = 4'h5;
    localparam logic [3:0] MODE_CAP_4TH = 4'h6;
    localparam logic [3:0] MODE_CAP_16TH = 4'h7;
    localparam logic [3:0] MODE_CMP_TRIG = 4'hB;

    // Mode class held in the upper two mode bits
    localparam logic [1:0] CLASS_CAPTURE = 2'h1;
    localparam logic [1:0] CLASS_COMPARE = 2'h2;
    localparam logic [1:0] CLASS_PWM = 2'h3;

    // Last prescaler count before a capture fires
    localparam logic [3:0] PRE_LAST_4TH = 4'h3;
    localparam logic [3:0] PRE_LAST_16TH = 4'hF;

    // Values after reset
    localparam logic [3:0] PRE_RESET = 4'h0;
    localparam logic [15:0] VALUE_RESET = 16'h0000;

    // Flag positions in the third peripheral flag register
    localparam int FLAG_POS_UNIT_ONE = 1;
    localparam int FLAG_POS_UNIT_TWO = 2;

    // Open-drain select positions in the port G direction register
    localparam int OD_POS_UNIT_ONE = 5;
    localparam int OD_POS_UNIT_TWO = 6;

    // Snapshot of a timer, split into high and low bytes
    typedef struct packed {
        logic [7:0] high;
        logic [7:0] low;
    } ccp_value_t;

endpackage

// *** ccp_capture_select.sv ***
// Capture unit pair with timer selection, trigger routing and pin muxing.
// Assumes all inputs are synchronous to i_clk except the capture pins,
// which are synchronised here; compare and PWM waveforms come from outside.
//
// How it works
// - Capture/compare on first or third timer
// - Both units run together, may share
// - Two timers, first and third; classes share timers
// - Open-drain select makes output open-drain
// - Pin select routes unit two pin
// - Compare trigger resets timer; unit two starts ADC
// - Trigger reset may disturb capturing unit
// - Both PWMs share period and update rate
// - Capture copies full 16-bit timer value
// - Falling, rising, 4th or 16th edge
// - Codes 0100, 0101, 0110, 0111 decode
// - Code 0000 disables; snapshot and flag keep their values
// - Capture sets sticky flag until cleared
// - New capture overwrites unread value silently
// - Output pin writes still count as edges
// - Mode change may falsely set flag
// - Prescaler cleared when off or not capturing
// - Prescaler switch keeps count, may interrupt
`timescale 1ns/1ps

// One capture unit: synchroniser, prescaler, snapshot, flag, trigger
module ccp_unit (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic [3:0] i_mode,
    input wire logic i_pin,
    input wire logic [15:0] i_timer,
    input wire logic i_flag_clear,
    input wire logic i_match,
    output ccp_pkg::ccp_value_t o_value,
    output logic o_flag,
    output logic o_trig
);
    logic sync_a; // First synchroniser stage
    logic sync_b; // Second synchroniser stage
    logic sync_c; // Delayed copy for edge detection
    logic rise; // One-cycle rising edge
    logic fall; // One-cycle falling edge
    logic is_capture; // Unit sits in a capture mode
    logic is_compare; // Unit sits in a compare mode
    logic pre_used; // Prescaled capture mode
    logic [3:0] pre_last; // Count at which the capture fires
    logic [3:0] pre_cnt; // Prescaler counter
    logic [3:0] next_pre_cnt; // Next prescaler count
    logic cap_evt; // Capture fires this cycle

    // Pin synchroniser; an output-driven pad reads back here too
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            sync_a <= 1'b0;
            sync_b <= 1'b0;
            sync_c <= 1'b0;
        end else begin
            sync_a <= i_pin;
            sync_b <= sync_a;
            sync_c <= sync_b;
        end
    end

    // Edges seen only past the second stage
    assign rise = sync_b & ~sync_c;
    assign fall = ~sync_b & sync_c;

    // Mode class decode
    assign is_capture = (i_mode[3:2] == ccp_pkg::CLASS_CAPTURE);
    assign is_compare = (i_mode[3:2] == ccp_pkg::CLASS_COMPARE) ||
                        (i_mode == ccp_pkg::MODE_CMP_TOGGLE);
    assign pre_used = (i_mode == ccp_pkg::MODE_CAP_4TH) ||
                      (i_mode == ccp_pkg::MODE_CAP_16TH);
    assign pre_last = (i_mode == ccp_pkg::MODE_CAP_4TH) ?
                      ccp_pkg::PRE_LAST_4TH : ccp_pkg::PRE_LAST_16TH;

    // Capture event select by mode code
    always_comb begin
        case (i_mode)
            ccp_pkg::MODE_CAP_FALL: begin
                cap_evt = fall;
            end
            ccp_pkg::MODE_CAP_RISE: begin
                cap_evt = rise;
            end
            ccp_pkg::MODE_CAP_4TH, ccp_pkg::MODE_CAP_16TH: begin
                // A count left over from a wider setting fires on the next rising edge
                cap_evt = rise && (pre_cnt >= pre_last);
            end
            default: begin
                cap_evt = 1'b0;
            end
        endcase
    end

    // Next prescaler count
    always_comb begin
        if (!is_capture) begin
            next_pre_cnt = ccp_pkg::PRE_RESET;
        end else if (pre_used && rise) begin
            next_pre_cnt = cap_evt ? ccp_pkg::PRE_RESET : pre_cnt + 4'h1;
        end else begin
            next_pre_cnt = pre_cnt; // Code switch keeps the count
        end
    end

    // Prescaler counter register
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            pre_cnt <= ccp_pkg::PRE_RESET;
        end else begin
            pre_cnt <= next_pre_cnt;
        end
    end

    // Snapshot; a later capture simply overwrites the old value
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            o_value <= ccp_pkg::VALUE_RESET;
        end else if (cap_evt) begin
            o_value <= i_timer;
        end
    end

    // Sticky flag; a new event wins over a clear in the same cycle
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            o_flag <= 1'b0;
        end else if (cap_evt || (is_compare && i_match)) begin
            o_flag <= 1'b1; // Edge leftovers after a mode change count
        end else if (i_flag_clear) begin
            o_flag <= 1'b0;
        end
    end

    // Special event trigger pulse on a compare match
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            o_trig <= 1'b0;
        end else begin
            o_trig <= (i_mode == ccp_pkg::MODE_CMP_TRIG) && i_match;
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);

    a_rise_snapshot: assert property (
        i_mode == ccp_pkg::MODE_CAP_RISE && rise |=>
            o_value == $past(i_timer) && o_flag)
        else $error("rising edge did not capture timer");
    a_fall_select: assert property (
        i_mode == ccp_pkg::MODE_CAP_FALL && !fall |=>
            o_value == $past(o_value))
        else $error("falling mode captured without falling edge");
    a_fourth_edge: assert property (
        i_mode == ccp_pkg::MODE_CAP_4TH && rise &&
        pre_cnt == ccp_pkg::PRE_LAST_4TH |=>
            o_flag && pre_cnt == ccp_pkg::PRE_RESET)
        else $error("fourth rising edge did not capture");
    a_off_resets: assert property (
        i_mode == ccp_pkg::MODE_OFF [*2] |-> pre_cnt == ccp_pkg::PRE_RESET)
        else $error("disabled unit kept prescaler count");
    a_noncap_clear: assert property (
        !is_capture |=> pre_cnt == ccp_pkg::PRE_RESET)
        else $error("prescaler not cleared outside capture");
    a_flag_sticky: assert property (
        o_flag && !i_flag_clear |=> o_flag)
        else $error("flag dropped without clear");
    a_overwrite_value: assert property (
        o_flag && cap_evt |=> o_value == $past(i_timer) && o_flag)
        else $error("second capture did not overwrite");
    a_switch_keeps: assert property (
        pre_used && $past(pre_used) && i_mode != $past(i_mode) &&
        !$past(rise) |->
            pre_cnt == $past(pre_cnt))
        else $error("prescaler cleared on code switch");
    a_one_per_edge: assert property (
        rise |=> !rise [*2])
        else $error("single edge seen twice");
    a_trig_pulse: assert property (
        i_mode == ccp_pkg::MODE_CMP_TRIG && i_match |=> o_trig)
        else $error("match gave no trigger");

    c_rise_capture: cover property (
        i_mode == ccp_pkg::MODE_CAP_RISE && rise ##1 o_flag);
    c_sixteenth: cover property (
        i_mode == ccp_pkg::MODE_CAP_16TH && cap_evt);
    c_overwrite: cover property (o_flag && cap_evt);
endmodule

// Top: two units, time base selection, trigger routing and pin drive
module ccp_capture_select (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic [3:0] i_unit_one_mode_code,
    input wire logic [3:0] i_unit_two_mode_code,
    input wire logic [1:0] i_timer_select,
    input wire logic [15:0] i_first_timer,
    input wire logic [15:0] i_third_timer,
    input wire logic i_unit_two_pin_select,
    input wire logic i_unit_one_open_drain,
    input wire logic i_unit_two_open_drain,
    input wire logic i_unit_one_pin,
    input wire logic i_default_port_pin,
    input wire logic i_alternate_port_pin,
    input wire logic [1:0] i_flag_clear,
    input wire logic [1:0] i_match,
    input wire logic i_pwm_period_match,
    input wire logic i_unit_one_level,
    input wire logic i_unit_two_level,
    output ccp_pkg::ccp_value_t o_unit_one_value,
    output ccp_pkg::ccp_value_t o_unit_two_value,
    output logic o_unit_one_irq_flag,
    output logic o_unit_two_irq_flag,
    output logic o_first_timer_reset,
    output logic o_third_timer_reset,
    output logic o_adc_start,
    output logic o_pwm_update,
    output logic o_unit_one_pin_out,
    output logic o_unit_one_pin_oe,
    output logic o_default_port_pin_out,
    output logic o_default_port_pin_oe,
    output logic o_alternate_port_pin_out,
    output logic o_alternate_port_pin_oe
);
    logic [15:0] base_one; // Time base of unit one
    logic [15:0] base_two; // Time base of unit two
    logic unit_two_pin; // Routed input pin of unit two
    logic trig_one; // Unit one trigger pulse
    logic trig_two; // Unit two trigger pulse
    logic pwm_one; // Unit one in PWM class
    logic pwm_two; // Unit two in PWM class
    logic drv_one_oe; // Unit one drive enable
    logic drv_two_oe; // Unit two drive enable

    // Output modes: compare class, toggle compare or PWM class
    function automatic logic out_mode(input logic [3:0] mode);
        out_mode = (mode[3:2] == ccp_pkg::CLASS_COMPARE) ||
                   (mode[3:2] == ccp_pkg::CLASS_PWM) ||
                   (mode == ccp_pkg::MODE_CMP_TOGGLE);
    endfunction

    // Each unit picks its own 16-bit timer; bit set means third timer
    assign base_one = i_timer_select[0] ? i_third_timer
                                        : i_first_timer;
    assign base_two = i_timer_select[1] ? i_third_timer
                                        : i_first_timer;
    // Unit two input comes from the selected pad
    assign unit_two_pin = i_unit_two_pin_select ? i_default_port_pin
                                                : i_alternate_port_pin;
    assign pwm_one = (i_unit_one_mode_code[3:2] == ccp_pkg::CLASS_PWM);
    assign pwm_two = (i_unit_two_mode_code[3:2] == ccp_pkg::CLASS_PWM);
    // Open drain drives only low, and releases the pin for a high
    assign drv_one_oe = out_mode(i_unit_one_mode_code) &&
                        !(i_unit_one_open_drain && i_unit_one_level);
    assign drv_two_oe = out_mode(i_unit_two_mode_code) &&
                        !(i_unit_two_open_drain && i_unit_two_level);

    // Unit one, running side by side with unit two
    ccp_unit u_unit_one (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_mode(i_unit_one_mode_code),
        .i_pin(i_unit_one_pin),
        .i_timer(base_one),
        .i_flag_clear(i_flag_clear[0]),
        .i_match(i_match[0]),
        .o_value(o_unit_one_value),
        .o_flag(o_unit_one_irq_flag),
        .o_trig(trig_one)
    );

    // Unit two, possibly sharing unit one's timer
    ccp_unit u_unit_two (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_mode(i_unit_two_mode_code),
        .i_pin(unit_two_pin),
        .i_timer(base_two),
        .i_flag_clear(i_flag_clear[1]),
        .i_match(i_match[1]),
        .o_value(o_unit_two_value),
        .o_flag(o_unit_two_irq_flag),
        .o_trig(trig_two)
    );

    // Trigger routing; a reset hits whichever unit shares that timer
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            o_first_timer_reset <= 1'b0;
            o_third_timer_reset <= 1'b0;
            o_adc_start <= 1'b0;
        end else begin
            o_first_timer_reset <= (trig_one && !i_timer_select[0]) ||
                                   (trig_two && !i_timer_select[1]);
            o_third_timer_reset <= (trig_one && i_timer_select[0]) ||
                                   (trig_two && i_timer_select[1]);
            o_adc_start <= trig_two; // Only unit two starts a conversion
        end
    end

    // Shared PWM update from the single PWM timer period
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            o_pwm_update <= 1'b0;
        end else begin
            o_pwm_update <= i_pwm_period_match && (pwm_one || pwm_two);
        end
    end

    // Pad drive for unit one
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            o_unit_one_pin_out <= 1'b0;
            o_unit_one_pin_oe <= 1'b0;
        end else begin
            o_unit_one_pin_out <= i_unit_one_level && !i_unit_one_open_drain;
            o_unit_one_pin_oe <= drv_one_oe;
        end
    end

    // Pad drive for unit two on the selected pad only
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            o_default_port_pin_out <= 1'b0;
            o_default_port_pin_oe <= 1'b0;
            o_alternate_port_pin_out <= 1'b0;
            o_alternate_port_pin_oe <= 1'b0;
        end else begin
            o_default_port_pin_out <= i_unit_two_level &&
                                      !i_unit_two_open_drain;
            o_alternate_port_pin_out <= i_unit_two_level &&
                                        !i_unit_two_open_drain;
            o_default_port_pin_oe <= drv_two_oe && i_unit_two_pin_select;
            o_alternate_port_pin_oe <= drv_two_oe &&
                                       !i_unit_two_pin_select;
        end
    end

    default clocking tb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);

    a_reset_route: assert property (
        trig_one && !i_timer_select[0] |=> o_first_timer_reset)
        else $error("unit one trigger did not reset first timer");
    a_adc_two_only: assert property (
        o_adc_start |-> $past(trig_two))
        else $error("conversion started without unit two trigger");
    a_alt_route: assert property (
        !i_unit_two_pin_select |=> !o_default_port_pin_oe)
        else $error("default pad driven while alternate selected");
    a_open_drain_low: assert property (
        i_unit_one_open_drain |=> !o_unit_one_pin_out)
        else $error("open-drain pin driven high");
    a_pwm_shared: assert property (
        pwm_one && pwm_two && i_pwm_period_match |=> o_pwm_update)
        else $error("shared PWM update missed");

    c_both_pwm: cover property (pwm_one && pwm_two && i_pwm_period_match);
    c_alt_pad: cover property (!i_unit_two_pin_select && drv_two_oe);
endmodule

// *** ccp_pin_source.sv ***
// Outside signal source that drives one capture pad of the unit pair.
// Assumes the bench asks for one level change at a time and waits.
`timescale 1ns/1ps

module ccp_pin_source (
    input wire logic i_clk,
    input wire logic i_req,
    input wire logic i_level,
    input wire logic [3:0] i_hold,
    output logic o_pin,
    output logic o_busy
);
    logic [3:0] hold_left; // Cycles the level is still held

    // Idle pad level before any request
    initial begin
        o_pin = 1'b0;
        o_busy = 1'b0;
        hold_left = 4'h0;
    end

    // Drive the asked level, then hold it so the edge is seen once
    always @(posedge i_clk) begin
        if (i_req) begin
            o_pin <= i_level;
            hold_left <= i_hold;
            o_busy <= 1'b1;
        end else if (hold_left != 4'h0) begin
            hold_left <= hold_left - 4'h1;
        end else begin
            o_busy <= 1'b0;
        end
    end
endmodule

// *** ccp_capture_select_tb_top.sv ***
// Bench for the capture unit pair: reference model, scenarios, verdict.
// Assumes the package and the pad source model are compiled first.
`timescale 1ns/1ps

module ccp_capture_select_tb_top;
    logic i_clk, i_rstn, psel, od, lvl, pwm_m, req, rlvl; // Stimulus
    logic [3:0] mode; // Same mode code for both units
    logic [1:0] tsel, fclr, match; // Per-unit controls
    logic [15:0] t1, t3, r; // Timer values and a random word
    logic [15:0] lfsr = 16'hEDB6; // Random source state
    ccp_pkg::ccp_value_t val1, val2; // Snapshots from the design
    logic flag1, flag2, rst1, rst3, adc, pwmu, src, busy; // Results
    logic p1o, p1e, pdo, pde, pao, pae; // Pad drive
    logic [15:0] ev[2]; // Expected snapshots
    logic ef[2]; // Expected flags
    int cnt[2]; // Expected prescaler counts
    int dst, err_count, checks, n_r1, n_r3, n_adc, n_pwm; // 0,1,2 = pad

    ccp_capture_select i_dut (
        .i_clk(i_clk), .i_rstn(i_rstn),
        .i_unit_one_mode_code(mode), .i_unit_two_mode_code(mode),
        .i_timer_select(tsel), .i_first_timer(t1), .i_third_timer(t3),
        .i_unit_two_pin_select(psel), .i_unit_one_open_drain(od),
        .i_unit_two_open_drain(od), .i_unit_one_pin(src & (dst == 0)),
        .i_default_port_pin(src & (dst == 1)),
        .i_alternate_port_pin(src & (dst == 2)),
        .i_flag_clear(fclr), .i_match(match), .i_pwm_period_match(pwm_m),
        .i_unit_one_level(lvl), .i_unit_two_level(~lvl),
        .o_unit_one_value(val1), .o_unit_two_value(val2),
        .o_unit_one_irq_flag(flag1), .o_unit_two_irq_flag(flag2),
        .o_first_timer_reset(rst1), .o_third_timer_reset(rst3),
        .o_adc_start(adc), .o_pwm_update(pwmu),
        .o_unit_one_pin_out(p1o), .o_unit_one_pin_oe(p1e),
        .o_default_port_pin_out(pdo), .o_default_port_pin_oe(pde),
        .o_alternate_port_pin_out(pao), .o_alternate_port_pin_oe(pae)
    );

    ccp_pin_source i_src (.i_clk(i_clk), .i_req(req), .i_level(rlvl),
        .i_hold(4'h6), .o_pin(src), .o_busy(busy));

    // Free-running core clock
    initial begin
        i_clk = 1'b0;
        forever #25 i_clk = ~i_clk;
    end

    // Count trigger, conversion and update pulses
    always @(posedge i_clk) begin
        n_r1 += (rst1 === 1'b1);
        n_r3 += (rst3 === 1'b1);
        n_adc += (adc === 1'b1);
        n_pwm += (pwmu === 1'b1);
    end

    // Next random word from the shift register
    function automatic logic [15:0] rnd();
        lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        return lfsr;
    endfunction

    // Wait n edges, then step just past the edge
    task automatic step(input int n);
        repeat (n) @(posedge i_clk);
        #2;
    endtask

    // Print the verdict and stop
    task automatic complete_run();
        if (err_count == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Compare a 16-bit result
    task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Compare a one-bit result
    task automatic chk_bit(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Software clear of both flags
    task automatic clear_flags();
        fclr = 2'b11;
        step(1);
        fclr = 2'b00;
        step(2);
        ef = '{1'b0, 1'b0};
        chk_bit(flag1, 1'b0);
        chk_bit(flag2, 1'b0);
    endtask

    // New mode for both units, through off unless switched directly
    task automatic set_modes(input logic [3:0] m, input logic direct);
        if (!direct) begin
            mode = ccp_pkg::MODE_OFF;
            step(3);
        end
        if (!direct || m[3:2] != ccp_pkg::CLASS_CAPTURE) begin
            cnt = '{0, 0};
        end
        mode = m;
        step(3);
        clear_flags();
    endtask

    // Move the source pad, predict both units, then compare
    task automatic move(input logic v);
        int u;
        int w;
        logic hit;
        logic [15:0] tv;
        t1 = rnd();
        t3 = rnd();
        u = (dst == 0) ? 0 : (((dst == 1) == psel) ? 1 : 2);
        if (u < 2) begin
            tv = tsel[u] ? t3 : t1;
            hit = (mode == ccp_pkg::MODE_CAP_RISE && v)
                || (mode == ccp_pkg::MODE_CAP_FALL && !v);
            if (v && mode[3:1] == 3'h3) begin
                // Prescaled modes fire when the count reaches its last
                hit = cnt[u] >= ((mode == ccp_pkg::MODE_CAP_4TH) ? 3 : 15);
                cnt[u] = hit ? 0 : cnt[u] + 1;
            end
            if (hit) begin
                ev[u] = tv;
                ef[u] = 1'b1;
            end
        end
        rlvl = v;
        req = 1'b1;
        step(1);
        req = 1'b0;
        for (w = 0; w < 20 && busy !== 1'b0; w++) begin
            step(1);
        end
        if (busy !== 1'b0) begin
            err_count++;
            complete_run();
        end
        chk_val(val1, ev[0]);
        chk_val(val2, ev[1]);
        chk_bit(flag1, ef[0]);
        chk_bit(flag2, ef[1]);
        if (rnd() < 16'h4000) begin
            clear_flags();
        end
    endtask

    // Full pulses on the source pad dst, routed or not
    task automatic pulses(input int n);
        repeat (n) begin
            move(1'b1);
            move(1'b0);
        end
    endtask

    // Main sequence
    initial begin
        {i_rstn, psel, od, lvl, pwm_m, req, rlvl} = '0;
        {mode, tsel, fclr, match, t1, t3, r} = '0;
        dst = 0;
        err_count = 0;
        checks = 0;
        ev = '{16'h0000, 16'h0000};
        ef = '{1'b0, 1'b0};
        cnt = '{0, 0};
        step(12);
        i_rstn = 1'b1;
        step(2);
        chk_val(val1, ccp_pkg::VALUE_RESET);
        chk_val(val2, ccp_pkg::VALUE_RESET);
        chk_bit(flag1 | flag2, 1'b0);
        // Each capture code on two pads; all three pads, both routings
        for (int i = 0; i < 8; i++) begin
            r = rnd();
            tsel = r[1:0];
            psel = i[2];
            dst = i % 3; // Source drives pad dst as an input, routed or not
            set_modes(ccp_pkg::MODE_CAP_FALL + 4'(i % 4), 1'b0);
            pulses((i % 4 == 3) ? 17 : 5);
        end
        // Direct prescaler switch keeps the count
        dst = 0;
        set_modes(ccp_pkg::MODE_CAP_16TH, 1'b0);
        pulses(5);
        set_modes(ccp_pkg::MODE_CAP_4TH, 1'b1);
        pulses(2);
        set_modes(ccp_pkg::MODE_CMP_TOGGLE, 1'b1);
        set_modes(ccp_pkg::MODE_CAP_16TH, 1'b1);
        pulses(16);
        // A reset in mid-run clears a part-way prescaler count
        pulses(3);
        i_rstn = 1'b0;
        step(2);
        i_rstn = 1'b1;
        ev = '{16'h0000, 16'h0000};
        ef = '{1'b0, 1'b0};
        cnt = '{0, 0};
        step(2);
        pulses(16);
        // Special event trigger per unit and time base
        for (int k = 0; k < 4; k++) begin
            tsel = {k[0], k[0]};
            set_modes(ccp_pkg::MODE_CMP_TRIG, 1'b0);
            n_r1 = 0;
            n_r3 = 0;
            n_adc = 0;
            match = k[1] ? 2'b10 : 2'b01;
            step(1);
            match = 2'b00;
            step(5);
            chk_val(16'(n_r1), {15'h0000, !k[0]});
            chk_val(16'(n_r3), {15'h0000, k[0]});
            chk_val(16'(n_adc), {15'h0000, k[1]});
            chk_bit(k[1] ? flag2 : flag1, 1'b1);
        end
        // Shared PWM period update
        set_modes({ccp_pkg::CLASS_PWM, 2'b00}, 1'b0);
        n_pwm = 0;
        pwm_m = 1'b1;
        step(1);
        pwm_m = 1'b0;
        step(4);
        chk_val(16'(n_pwm), 16'h0001);
        // Open-drain and pad routing of the output drivers
        for (int k = 0; k < 8; k++) begin
            od = k[0];
            lvl = k[1];
            psel = k[2];
            step(3);
            chk_bit(p1e, !od | !lvl);
            chk_bit(p1o, !od & lvl);
            chk_bit(psel ? pde : pae, !od | lvl);
            chk_bit(psel ? pae : pde, 1'b0);
            chk_bit(psel ? pdo : pao, !od & !lvl);
        end
        complete_run();
    end
endmodule
